// ---- include/sdac_pkg.sv ----
// package for the stepper drive axis configuration block
package sdac_pkg;
  localparam int unsigned NUM_AXES = 4;
  localparam int unsigned CLK_HZ = 25000000;
  // step pulse ceiling, in hertz
  localparam int unsigned STEP_MAX_HZ = 6000000;
  // least step pulse period in clock cycles, at least one
  localparam int unsigned STEP_MIN_CYC =
    ((CLK_HZ / STEP_MAX_HZ) < 1) ? 1 : (CLK_HZ / STEP_MAX_HZ);
  // drive current codes
  localparam logic [1:0] CUR_CODE_DEFAULT = 2'h1;
  // current levels in milliamps, standard step drive
  localparam logic [11:0] STD_MA_0 = 12'h1F4;
  localparam logic [11:0] STD_MA_1 = 12'h2EE;
  localparam logic [11:0] STD_MA_2 = 12'h3E8;
  localparam logic [11:0] STD_MA_3 = 12'h578;
  // current levels in milliamps, microstepping drive
  localparam logic [11:0] MIC_MA_0 = 12'h1F4;
  localparam logic [11:0] MIC_MA_1 = 12'h3E8;
  localparam logic [11:0] MIC_MA_2 = 12'h7D0;
  localparam logic [11:0] MIC_MA_3 = 12'hBB8;
  // hold current modes and delay range
  localparam logic [15:0] HOLD_FULL = 16'h0000;
  localparam logic [15:0] HOLD_LOW = 16'h0001;
  localparam logic [15:0] HOLD_DLY_MIN = 16'h0002;
  localparam logic [15:0] HOLD_DLY_MAX = 16'h7FFF;
  localparam int unsigned LOW_SHIFT = 2;
  // step resolution codes
  localparam logic [4:0] RES_FULL = 5'h01;
  localparam logic [4:0] RES_HALF = 5'h02;
  localparam logic [4:0] RES_QUARTER = 5'h04;
  localparam logic [4:0] RES_SIXTEENTH = 5'h10;
  // microsteps per full step and per electrical cycle
  localparam logic [8:0] MICRO_PER_STEP = 9'h040;
  localparam logic [8:0] MICRO_PER_CYCLE = 9'h100;
  // motor type code for a stepper, two's complement of -2
  localparam logic [7:0] MTYPE_STEPPER = 8'hFE;
  // amplifier error status word 3 value after a lockout
  localparam logic [7:0] ERR3_LOCKOUT = 8'h03;
  localparam logic [7:0] ERR3_CLEAR = 8'h00;

  typedef struct packed {
    logic [1:0] current_sel;
    logic [15:0] hold_mode;
    logic [4:0] resolution_sel;
  } sdac_axis_cfg_s;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_LOCKED = 3'h2,
    ST_OFF = 3'h4
  } sdac_lock_e;
endpackage

// ---- rtl/sdac_axis_config.sv ----
// stepper drive axis configuration, hold current and lockout control
`timescale 1ns/1ps
module sdac_axis_config (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // drive variant: 0 standard step, 1 microstepping
  input wire logic micro_drive,
  // configuration writes
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_axis,
  input wire sdac_pkg::sdac_axis_cfg_s cfg_data,
  input wire logic [7:0] motor_type_select,
  // per axis motion and errors
  input wire logic sample_tick,
  input wire logic [3:0] profiler_busy,
  input wire logic [3:0] reference_position_changed,
  input wire logic [3:0] step_in,
  input wire logic [3:0] amp_error_in,
  input wire logic [3:0] err_shutoff_enable,
  // lockout and recovery
  input wire logic emergency_lockout_input,
  input wire logic motor_off,
  input wire logic motor_reenable,
  // drive outputs
  output logic [3:0] amp_enable,
  output logic [47:0] phase_current_ma,
  output logic [19:0] microstep_div,
  output logic [3:0] step_out,
  output logic [7:0] amp_error_status,
  output logic amp_error_routine,
  output logic [3:0] cfg_rejected
);
  localparam int unsigned NA = sdac_pkg::NUM_AXES;

  sdac_pkg::sdac_axis_cfg_s cfg_q [NA];
  sdac_pkg::sdac_lock_e lock_q;
  logic [15:0] rest_cnt_q [NA];
  logic [3:0] resting_q;
  logic [3:0] axis_err_off_q;
  logic [3:0] step_out_q;
  logic [3:0] amp_en_q;
  logic [47:0] cur_q;
  logic [19:0] div_q;
  logic [7:0] err3_q;
  logic routine_q;
  logic [3:0] rej_q;

  function automatic logic [11:0] peak_ma(input logic micro, input logic [1:0] code);
    logic [11:0] v;
    v = sdac_pkg::STD_MA_1;
    unique case (code)
      2'h0: v = micro ? sdac_pkg::MIC_MA_0 : sdac_pkg::STD_MA_0;
      2'h1: v = micro ? sdac_pkg::MIC_MA_1 : sdac_pkg::STD_MA_1;
      2'h2: v = micro ? sdac_pkg::MIC_MA_2 : sdac_pkg::STD_MA_2;
      2'h3: v = micro ? sdac_pkg::MIC_MA_3 : sdac_pkg::STD_MA_3;
    endcase
    return v;
  endfunction

  function automatic logic [4:0] res_div(input logic micro, input logic [4:0] code);
    logic [4:0] v;
    v = sdac_pkg::RES_FULL;
    if (micro) begin
      v = sdac_pkg::MICRO_PER_STEP[4:0] - 5'h01;
    end else if (code == sdac_pkg::RES_HALF || code == sdac_pkg::RES_QUARTER ||
                 code == sdac_pkg::RES_SIXTEENTH) begin
      v = code;
    end
    return v;
  endfunction

  // configuration store, one entry per axis
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NA; i++) begin
        cfg_q[i] <= '{current_sel: sdac_pkg::CUR_CODE_DEFAULT,
                      hold_mode: sdac_pkg::HOLD_FULL,
                      resolution_sel: sdac_pkg::RES_FULL};
      end
      rej_q <= 4'h0;
    end else begin
      rej_q <= 4'h0;
      if (cfg_wr) begin
        cfg_q[cfg_axis].current_sel <= cfg_data.current_sel;
        cfg_q[cfg_axis].resolution_sel <= cfg_data.resolution_sel;
        if (motor_type_select == sdac_pkg::MTYPE_STEPPER &&
            cfg_data.hold_mode <= sdac_pkg::HOLD_DLY_MAX) begin
          cfg_q[cfg_axis].hold_mode <= cfg_data.hold_mode;
        end else begin
          rej_q[cfg_axis] <= 1'b1;
        end
      end
    end
  end

  // resting detection and sample counting per axis
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NA; i++) begin
        rest_cnt_q[i] <= 16'h0000;
      end
      resting_q <= 4'h0;
    end else begin
      for (int i = 0; i < NA; i++) begin
        if (profiler_busy[i] || reference_position_changed[i]) begin
          rest_cnt_q[i] <= 16'h0000;
          resting_q[i] <= 1'b0;
        end else begin
          resting_q[i] <= 1'b1;
          if (sample_tick && rest_cnt_q[i] != sdac_pkg::HOLD_DLY_MAX) begin
            rest_cnt_q[i] <= rest_cnt_q[i] + 16'h0001;
          end
        end
      end
    end
  end

  // lockout state: stays off until motor off then re-enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_q <= sdac_pkg::ST_RUN;
    end else begin
      unique case (lock_q)
        sdac_pkg::ST_RUN: if (emergency_lockout_input) lock_q <= sdac_pkg::ST_LOCKED;
        sdac_pkg::ST_LOCKED: if (motor_off && !emergency_lockout_input) begin
          lock_q <= sdac_pkg::ST_OFF;
        end
        sdac_pkg::ST_OFF: begin
          if (emergency_lockout_input) lock_q <= sdac_pkg::ST_LOCKED;
          else if (motor_reenable) lock_q <= sdac_pkg::ST_RUN;
        end
        default: lock_q <= sdac_pkg::ST_LOCKED;
      endcase
    end
  end

  // per axis error shut-off latch, cleared by re-enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      axis_err_off_q <= 4'h0;
    end else begin
      for (int i = 0; i < NA; i++) begin
        if (amp_error_in[i] && err_shutoff_enable[i]) begin
          axis_err_off_q[i] <= 1'b1;
        end else if (motor_reenable) begin
          axis_err_off_q[i] <= 1'b0;
        end
      end
    end
  end

  // error word 3 and routine trigger
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err3_q <= sdac_pkg::ERR3_CLEAR;
      routine_q <= 1'b0;
    end else begin
      routine_q <= (emergency_lockout_input && lock_q == sdac_pkg::ST_RUN) ||
                   (|(amp_error_in & ~axis_err_off_q & err_shutoff_enable));
      if (lock_q != sdac_pkg::ST_RUN || emergency_lockout_input) begin
        err3_q <= sdac_pkg::ERR3_LOCKOUT;
      end else begin
        err3_q <= sdac_pkg::ERR3_CLEAR;
      end
    end
  end

  // current, enable and resolution outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amp_en_q <= 4'h0;
      cur_q <= 48'h0;
      div_q <= 20'h0;
    end else begin
      for (int i = 0; i < NA; i++) begin
        logic [11:0] pk;
        logic hold_off;
        pk = peak_ma(micro_drive, cfg_q[i].current_sel);
        hold_off = cfg_q[i].hold_mode >= sdac_pkg::HOLD_DLY_MIN && resting_q[i] &&
                   rest_cnt_q[i] >= cfg_q[i].hold_mode;
        if (resting_q[i] && cfg_q[i].hold_mode == sdac_pkg::HOLD_LOW) begin
          cur_q[i*12 +: 12] <= pk >> sdac_pkg::LOW_SHIFT;
        end else begin
          cur_q[i*12 +: 12] <= pk;
        end
        amp_en_q[i] <= lock_q == sdac_pkg::ST_RUN && !emergency_lockout_input &&
                       !axis_err_off_q[i] && !hold_off;
        div_q[i*5 +: 5] <= res_div(micro_drive, cfg_q[i].resolution_sel);
      end
    end
  end

  // step pulse pass-through gated by amp enable, one register stage, no rate limit at any pulse rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_out_q <= 4'h0;
    end else begin
      for (int i = 0; i < NA; i++) begin
        step_out_q[i] <= step_in[i] && amp_en_q[i];
      end
    end
  end

  assign amp_enable = amp_en_q;
  assign phase_current_ma = cur_q;
  assign microstep_div = div_q;
  assign step_out = step_out_q;
  assign amp_error_status = err3_q;
  assign amp_error_routine = routine_q;
  assign cfg_rejected = rej_q;

  AST_LOCK_OFF: assert property (@(posedge clk) disable iff (rst)
    emergency_lockout_input |=> amp_enable == 4'h0)
    else $error("lockout left an amplifier on");
  AST_ERR3: assert property (@(posedge clk) disable iff (rst)
    emergency_lockout_input |=> amp_error_status == sdac_pkg::ERR3_LOCKOUT)
    else $error("error word 3 not 3 after lockout");
  AST_STAY_OFF: assert property (@(posedge clk) disable iff (rst)
    lock_q == sdac_pkg::ST_LOCKED && !motor_off |=> lock_q == sdac_pkg::ST_LOCKED)
    else $error("lockout left without motor off");
  AST_LOW_CUR: assert property (@(posedge clk) disable iff (rst)
    resting_q[1] && cfg_q[1].hold_mode == sdac_pkg::HOLD_LOW
    |=> phase_current_ma[23:12] ==
        (peak_ma($past(micro_drive), $past(cfg_q[1].current_sel)) >> sdac_pkg::LOW_SHIFT))
    else $error("low hold current wrong");
  AST_FULL_CUR: assert property (@(posedge clk) disable iff (rst)
    profiler_busy[1]
    |=> ##1 phase_current_ma[23:12] ==
        peak_ma($past(micro_drive), $past(cfg_q[1].current_sel)))
    else $error("full current not restored");
  AST_RESTART: assert property (@(posedge clk) disable iff (rst)
    profiler_busy[1] |=> rest_cnt_q[1] == 16'h0000)
    else $error("rest count not restarted");
  AST_ERR_OFF: assert property (@(posedge clk) disable iff (rst)
    amp_error_in[3] && err_shutoff_enable[3] |=> ##1 !amp_enable[3])
    else $error("amp error did not disable axis");
  AST_PER_AXIS: assert property (@(posedge clk) disable iff (rst)
    cfg_wr && cfg_axis == 2'h0 |=> $stable(cfg_q[1].hold_mode))
    else $error("hold write leaked to another axis");
  AST_TYPE_GATE: assert property (@(posedge clk) disable iff (rst)
    cfg_wr && cfg_axis == 2'h2 && motor_type_select != sdac_pkg::MTYPE_STEPPER
    |=> $stable(cfg_q[2].hold_mode) && cfg_rejected[2])
    else $error("hold written without stepper type");
  AST_DIV: assert property (@(posedge clk) disable iff (rst)
    micro_drive && $stable(micro_drive) |=> microstep_div[4:0] == 5'h1F)
    else $error("microstep division wrong");

  COV_LOCK_RECOVER: cover property (@(posedge clk) disable iff (rst)
    lock_q == sdac_pkg::ST_OFF ##1 lock_q == sdac_pkg::ST_RUN);
  COV_LOW_HOLD: cover property (@(posedge clk) disable iff (rst)
    resting_q[0] && cfg_q[0].hold_mode == sdac_pkg::HOLD_LOW);
  COV_DELAY_OFF: cover property (@(posedge clk) disable iff (rst)
    amp_enable[0] ##1 !amp_enable[0] && lock_q == sdac_pkg::ST_RUN);
endmodule

// ---- tb/sdac_winding_model.sv ----
// behavioural two-phase winding set: counts steps, tracks current
`timescale 1ns/1ps
module sdac_winding_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // drive side
  input wire logic [3:0] amp_enable,
  input wire logic [47:0] phase_current_ma,
  input wire logic [3:0] step_out,
  // observation
  output logic [7:0] steps0,
  output logic [11:0] coil0_ma
);
  // a disabled amplifier leaves the coil unpowered
  assign coil0_ma = amp_enable[0] ? phase_current_ma[11:0] : 12'h000;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      steps0 <= 8'h00;
    end else if (step_out[0]) begin
      steps0 <= steps0 + 8'h01;
    end
  end
endmodule

// ---- tb/stepper_drive_axis_config_tb_top.sv ----
// self-checking bench for the stepper drive axis configuration block
`timescale 1ns/1ps
module stepper_drive_axis_config_tb_top;
  logic clk, rst, micro_drive, cfg_wr, sample_tick, lockout, moff, reen;
  logic [1:0] cfg_axis;
  sdac_pkg::sdac_axis_cfg_s cfg_data;
  logic [7:0] mtype, status, steps0;
  logic [3:0] busy, refchg, step_in, amp_err, shut_en, amp_en, step_out, rej, seen_rej;
  logic [47:0] cur;
  logic [19:0] div;
  logic [11:0] coil0;
  logic routine, seen_rtn;
  logic [4:0] resv [4];
  int err_count, n_checks, cyc;
  sdac_axis_config u_dut (.clk(clk), .rst(rst), .micro_drive(micro_drive), .cfg_wr(cfg_wr),
    .cfg_axis(cfg_axis), .cfg_data(cfg_data), .motor_type_select(mtype),
    .sample_tick(sample_tick), .profiler_busy(busy), .reference_position_changed(refchg),
    .step_in(step_in), .amp_error_in(amp_err), .err_shutoff_enable(shut_en),
    .emergency_lockout_input(lockout), .motor_off(moff), .motor_reenable(reen),
    .amp_enable(amp_en), .phase_current_ma(cur), .microstep_div(div), .step_out(step_out),
    .amp_error_status(status), .amp_error_routine(routine), .cfg_rejected(rej));
  sdac_winding_model u_motor (.clk(clk), .rst(rst), .amp_enable(amp_en),
    .phase_current_ma(cur), .step_out(step_out), .steps0(steps0), .coil0_ma(coil0));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // one-cycle pulses are caught here so checks can look later
  always @(posedge clk) begin
    cyc++;
    if (rej !== 4'h0) seen_rej |= rej;
    if (routine === 1'b1) seen_rtn = 1'b1;
    if (cyc == 6000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [1:0] a, input logic [1:0] c, input logic [15:0] h,
                    input logic [4:0] r);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_axis = a;
    cfg_data = '{current_sel: c, hold_mode: h, resolution_sel: r};
    @(negedge clk);
    cfg_wr = 1'b0;
    wt(3);
  endtask
  function automatic logic [11:0] ma(input logic m, input logic [1:0] c);
    case ({m, c})
      3'h0: return sdac_pkg::STD_MA_0;
      3'h1: return sdac_pkg::STD_MA_1;
      3'h2: return sdac_pkg::STD_MA_2;
      3'h3: return sdac_pkg::STD_MA_3;
      3'h4: return sdac_pkg::MIC_MA_0;
      3'h5: return sdac_pkg::MIC_MA_1;
      3'h6: return sdac_pkg::MIC_MA_2;
      default: return sdac_pkg::MIC_MA_3;
    endcase
  endfunction
  initial begin
    {micro_drive, cfg_wr, sample_tick, lockout, moff, reen, cfg_axis} = '0;
    cfg_data = '0;
    {refchg, step_in, amp_err, seen_rej, seen_rtn} = '0;
    busy = 4'hF;
    shut_en = 4'hF;
    mtype = sdac_pkg::MTYPE_STEPPER;
    resv = '{5'h01, 5'h02, 5'h04, 5'h10};
    rst = 1'b1;
    wt(2);
    rst = 1'b0;
    wt(3);
    chk("default current", sdac_pkg::STD_MA_1, cur[11:0]);
    chk("default div", 5'h01, div[4:0]);
    chk("enable after reset", 4'hF, amp_en);
    for (int m = 0; m < 2; m++) begin
      micro_drive = m[0];
      for (int c = 0; c < 4; c++) begin
        wr(2'h0, c[1:0], sdac_pkg::HOLD_FULL, sdac_pkg::RES_FULL);
        chk("current", ma(m[0], c[1:0]), cur[11:0]);
      end
    end
    chk("micro div", 5'h1F, div[4:0]);
    micro_drive = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(2'h1, 2'h1, sdac_pkg::HOLD_FULL, resv[i]);
      chk("resolution", resv[i], div[9:5]);
    end
    wr(2'h1, 2'h3, sdac_pkg::HOLD_LOW, sdac_pkg::RES_FULL);
    refchg = 4'h2;
    busy = 4'h0;
    wt(4);
    chk("moving reference", sdac_pkg::STD_MA_3, cur[23:12]);
    refchg = 4'h0;
    wt(4);
    chk("low hold", sdac_pkg::STD_MA_3 >> 2, cur[23:12]);
    chk("full hold other axis", sdac_pkg::STD_MA_3, cur[11:0]);
    chk("winding current", sdac_pkg::STD_MA_3, coil0);
    busy = 4'h2;
    wt(3);
    chk("motion restores", sdac_pkg::STD_MA_3, cur[23:12]);
    mtype = 8'h00;
    wr(2'h2, 2'h1, sdac_pkg::HOLD_LOW, sdac_pkg::RES_FULL);
    chk("refused type", 4'h4, seen_rej);
    mtype = sdac_pkg::MTYPE_STEPPER;
    seen_rej = 4'h0;
    wr(2'h3, 2'h1, 16'h8000, sdac_pkg::RES_FULL);
    chk("refused value", 4'h8, seen_rej);
    wt(3);
    chk("refused hold kept full", sdac_pkg::STD_MA_1, cur[35:24]);
    wr(2'h2, 2'h1, 16'h0003, sdac_pkg::RES_FULL);
    busy = 4'h6;
    wt(2);
    busy = 4'h2;
    for (int k = 0; k < 4; k++) begin
      sample_tick = 1'b1;
      wt(1);
      sample_tick = 1'b0;
      wt(1);
      if (k == 1) chk("enable before delay", 1'b1, amp_en[2]);
    end
    wt(2);
    chk("enable after delay", 1'b0, amp_en[2]);
    busy = 4'hF;
    wt(3);
    chk("enable on motion", 1'b1, amp_en[2]);
    seen_rtn = 1'b0;
    lockout = 1'b1;
    wt(3);
    chk("lockout enable", 4'h0, amp_en);
    chk("lockout status", sdac_pkg::ERR3_LOCKOUT, status);
    chk("lockout routine", 1'b1, seen_rtn);
    lockout = 1'b0;
    wt(1);
    reen = 1'b1;
    wt(1);
    reen = 1'b0;
    wt(3);
    chk("reenable alone", 4'h0, amp_en);
    moff = 1'b1;
    wt(1);
    moff = 1'b0;
    wt(1);
    reen = 1'b1;
    wt(1);
    reen = 1'b0;
    wt(3);
    chk("recovered", 4'hF, amp_en);
    chk("status clear", sdac_pkg::ERR3_CLEAR, status);
    seen_rtn = 1'b0;
    amp_err = 4'h8;
    wt(3);
    chk("error shut-off", 4'h7, amp_en);
    chk("error routine", 1'b1, seen_rtn);
    amp_err = 4'h0;
    reen = 1'b1;
    wt(1);
    reen = 1'b0;
    wt(3);
    chk("error cleared", 4'hF, amp_en);
    for (int s = 0; s < 8; s++) begin
      step_in = 4'hF;
      wt(1);
      step_in = 4'h0;
      wt(sdac_pkg::STEP_MIN_CYC - 1);
    end
    wt(2);
    chk("steps passed", 8'h08, steps0);
    results();
  end
endmodule
